/* rtl/crt_pkg.sv */
// Operation
// RULE1: external logic arbitrates RAM in shared mode
// RULE2: transparent mode: only controller addresses RAM
// RULE3: external mux favours host on request
// RULE4: external gating: refresh while phase low
// RULE5: vertical retrace status bit reads blanking
// RULE6: interleaved: update address during high phase
// RULE7: host loads update address before access
// RULE8: retrace mode: update address only blanked
// RULE9: update strobe marks update address present
// RULE10: external latches hold host write data
// RULE11: skew bits delay enable and cursor
// RULE12: linear refresh: per char, row adds count
// RULE13: mode bit selects linear or row/column
// RULE14: update address increments after each access
// RULE15: dummy access stores nothing, triggers update
// RULE16: cursor skew delays one character period
// RULE17: enable skew delays one character period
package crt_pkg;
  localparam int AW = 14;
  localparam int IRQ_W = 2;
  // register indices; byte address is index times four
  localparam logic [5:0] IDX_HTOTAL = 6'h00;
  localparam logic [5:0] IDX_HDISP = 6'h01;
  localparam logic [5:0] IDX_VTOTAL = 6'h04;
  localparam logic [5:0] IDX_VDISP = 6'h06;
  localparam logic [5:0] IDX_MODE_CONTROL_REG = 6'h08;
  localparam logic [5:0] IDX_MAXSCAN = 6'h09;
  localparam logic [5:0] IDX_START_HI = 6'h0c;
  localparam logic [5:0] IDX_START_LO = 6'h0d;
  localparam logic [5:0] IDX_UPDATE_ADDRESS_HIGH_REG = 6'h12;
  localparam logic [5:0] IDX_UPDATE_ADDRESS_LOW_REG = 6'h13;
  localparam logic [5:0] IDX_DUMMY_UPDATE_LOCATION = 6'h1f;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h21;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h22;
  // mode control bits
  localparam int MODE_ROWCOL = 2;
  localparam int MODE_TRANSP = 3;
  localparam int MODE_DE_SKEW = 4;
  localparam int MODE_CUR_SKEW = 5;
  localparam int MODE_RETRACE = 7;
  // status bits
  localparam int ST_VRETRACE = 5;
  localparam int ST_UPD_READY = 7;
  // interrupt bits
  localparam int IRQ_UPD = 0;
  localparam int IRQ_VBL = 1;
  // reset values
  localparam logic [7:0] HTOTAL_RST = 8'h59;
  localparam logic [7:0] HDISP_RST = 8'h50;
  localparam logic [6:0] VTOTAL_RST = 7'h21;
  localparam logic [6:0] VDISP_RST = 7'h18;
  localparam logic [4:0] MAXSCAN_RST = 5'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [13:0] ADDR_RST = 14'h0000;

  typedef struct packed {
    logic [7:0] htotal;
    logic [7:0] hdisp;
    logic [6:0] vtotal;
    logic [6:0] vdisp;
    logic [4:0] maxscan;
    logic [13:0] start;
    logic rowcol;
  } crt_timing_t;

  typedef struct packed {
    logic [13:0] addr;
    logic hblank;
    logic vblank;
  } crt_scan_t;

  typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT, UPD_DRIVE} crt_upd_t;
endpackage : crt_pkg

/* rtl/crt_addr_gen.sv */
`timescale 1ns/1ns
module crt_addr_gen
  import crt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire crt_timing_t cfg_i,
  output crt_scan_t scan_o
);
  logic [7:0] hcnt_q, hcnt_d;
  logic [4:0] scan_q, scan_d;
  logic [6:0] row_q, row_d;
  logic [13:0] rstart_q, rstart_d;
  logic [13:0] addr_q, addr_d;
  logic [7:0] col;
  logic [5:0] rowa;

  always_comb
  begin
    hcnt_d = hcnt_q;
    scan_d = scan_q;
    row_d = row_q;
    rstart_d = rstart_q;
    addr_d = addr_q;
    if (tick_i)
    begin
      if (hcnt_q == cfg_i.htotal)
      begin
        hcnt_d = 8'h00;
        if (scan_q == cfg_i.maxscan)
        begin
          scan_d = 5'h00;
          if (row_q == cfg_i.vtotal)
          begin
            row_d = 7'h00;
            rstart_d = cfg_i.start;
          end
          else
          begin
            row_d = row_q + 7'h01;
            rstart_d = rstart_q + {6'h00, cfg_i.hdisp}; // RULE12
          end
        end
        else
          scan_d = scan_q + 5'h01;
        addr_d = rstart_d;
      end
      else
      begin
        hcnt_d = hcnt_q + 8'h01;
        addr_d = addr_q + 14'h0001; // RULE12
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hcnt_q <= 8'h00;
      scan_q <= 5'h00;
      row_q <= 7'h00;
      rstart_q <= ADDR_RST;
      addr_q <= ADDR_RST;
    end
    else
    begin
      hcnt_q <= hcnt_d;
      scan_q <= scan_d;
      row_q <= row_d;
      rstart_q <= rstart_d;
      addr_q <= addr_d;
    end
  end

  // row/column: low byte column, upper six bits row
  assign col = cfg_i.start[7:0] + hcnt_q;
  assign rowa = cfg_i.start[13:8] + row_q[5:0];
  assign scan_o.addr = cfg_i.rowcol ? {rowa, col} : addr_q; // RULE13
  assign scan_o.hblank = (hcnt_q >= cfg_i.hdisp);
  assign scan_o.vblank = (row_q >= cfg_i.vdisp);

  property p_lin_step;
    @(posedge clk_i) disable iff (rst_i)
    (tick_i && hcnt_q != cfg_i.htotal) |=> addr_q == $past(addr_q) + 14'h0001;
  endproperty
  a_lin_step: assert property (p_lin_step) // RULE12
    else $error("linear address did not advance");

  property p_rowcol;
    @(posedge clk_i) disable iff (rst_i)
    (cfg_i.rowcol && tick_i && hcnt_q != cfg_i.htotal) |=> !cfg_i.rowcol ||
      8'(scan_o.addr[7:0] - cfg_i.start[7:0]) ==
      8'($past(scan_o.addr[7:0] - cfg_i.start[7:0]) + 8'h01);
  endproperty
  a_rowcol: assert property (p_rowcol) // RULE13
    else $error("row/column low byte did not step by column");
endmodule : crt_addr_gen

/* rtl/crt_skew.sv */
`timescale 1ns/1ns
module crt_skew
  import crt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [1:0] raw_i,
  input wire logic [1:0] skew_i,
  output logic [1:0] out_o
);
  logic [1:0] dly_q, dly_d, out_d;

  // bit 0 display enable, bit 1 cursor
  for (genvar i = 0; i < 2; i++)
  begin : g_bit
    always_comb
    begin
      dly_d[i] = tick_i ? raw_i[i] : dly_q[i];
      out_d[i] = skew_i[i] ? dly_q[i] : raw_i[i]; // RULE11 RULE16 RULE17
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        dly_q[i] <= 1'b0;
        out_o[i] <= 1'b0;
      end
      else
      begin
        dly_q[i] <= dly_d[i];
        out_o[i] <= out_d[i];
      end
    end
  end

  property p_cur_skew;
    @(posedge clk_i) disable iff (rst_i)
    skew_i[1] |=> out_o[1] == $past(dly_q[1]);
  endproperty
  a_cur_skew: assert property (p_cur_skew) // RULE16
    else $error("cursor not taken from delayed copy");

  property p_de_skew;
    @(posedge clk_i) disable iff (rst_i)
    (skew_i[0] && tick_i) ##1 (skew_i[0] && !tick_i) |=>
      out_o[0] == $past(raw_i[0], 2);
  endproperty
  a_de_skew: assert property (p_de_skew) // RULE17
    else $error("display enable skew lost one character");

  property p_de_direct;
    @(posedge clk_i) disable iff (rst_i)
    !skew_i[0] |=> out_o[0] == $past(raw_i[0]);
  endproperty
  a_de_direct: assert property (p_de_direct) // RULE11
    else $error("unskewed display enable delayed");
endmodule : crt_skew

/* rtl/crt_display_addr.sv */
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ns
module crt_display_addr
  import crt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic character_clock_i,
  input wire logic phi2_i,
  input wire logic cursor_i,
  output logic [13:0] display_memory_address_out_o,
  output logic update_strobe_o,
  output logic display_enable_o,
  output logic cursor_o,
  output logic irq_o
);
  // pin synchronisers
  logic cc_s1_q, cc_s2_q, cc_s3_q;
  logic ph_s1_q, ph_s2_q, ph_s3_q;
  logic tick, ph_rise, ph_fall;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cc_s1_q <= 1'b0;
      cc_s2_q <= 1'b0;
      cc_s3_q <= 1'b0;
      ph_s1_q <= 1'b0;
      ph_s2_q <= 1'b0;
      ph_s3_q <= 1'b0;
    end
    else
    begin
      cc_s1_q <= character_clock_i;
      cc_s2_q <= cc_s1_q;
      cc_s3_q <= cc_s2_q;
      ph_s1_q <= phi2_i;
      ph_s2_q <= ph_s1_q;
      ph_s3_q <= ph_s2_q;
    end
  end

  assign tick = cc_s2_q & ~cc_s3_q;
  assign ph_rise = ph_s2_q & ~ph_s3_q;
  assign ph_fall = ~ph_s2_q & ph_s3_q;

  // registers
  crt_timing_t cfg_q, cfg_d;
  logic [7:0] mode_q, mode_d;
  logic [13:0] upd_q, upd_d;
  logic ready_q, ready_d;
  logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
  logic ack_d;
  logic [31:0] rdat_d;
  logic req, wr, wr0, wr1;
  logic [5:0] idx;
  logic dummy_hit;
  logic [IRQ_W-1:0] ev;

  // upd state
  crt_upd_t ust_q, ust_d;
  logic upd_done;
  logic [13:0] ma_d;
  logic stb_d, irq_d;
  logic transp, retrace, blank, drive_ok;
  logic vbl_q;
  crt_scan_t scan;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = wb_adr_i[7:2];
  assign wr = req & wb_we_i;
  assign wr0 = wr & wb_sel_i[0];
  assign wr1 = wr & wb_sel_i[1];
  assign transp = mode_q[MODE_TRANSP];
  assign retrace = mode_q[MODE_RETRACE];
  assign blank = scan.hblank | scan.vblank;
  // counters step on tick, so a tick cycle is not safe to drive
  assign drive_ok = blank & ~tick;
  // either direction counts; nothing is stored
  assign dummy_hit = req & transp & (idx == IDX_DUMMY_UPDATE_LOCATION);

  always_comb
  begin
    cfg_d = cfg_q;
    mode_d = mode_q;
    upd_d = upd_q;
    imask_d = imask_q;
    if (wr0)
    begin
      unique case (idx)
        IDX_HTOTAL: cfg_d.htotal = wb_dat_i[7:0];
        IDX_HDISP: cfg_d.hdisp = wb_dat_i[7:0];
        IDX_VTOTAL: cfg_d.vtotal = wb_dat_i[6:0];
        IDX_VDISP: cfg_d.vdisp = wb_dat_i[6:0];
        IDX_MAXSCAN: cfg_d.maxscan = wb_dat_i[4:0];
        IDX_MODE_CONTROL_REG: mode_d = wb_dat_i[7:0];
        IDX_START_HI: cfg_d.start[13:8] = wb_dat_i[5:0];
        IDX_START_LO: cfg_d.start[7:0] = wb_dat_i[7:0];
        IDX_UPDATE_ADDRESS_HIGH_REG: upd_d[13:8] = wb_dat_i[5:0];
        IDX_UPDATE_ADDRESS_LOW_REG: upd_d[7:0] = wb_dat_i[7:0];
        IDX_IRQ_MASK: imask_d = wb_dat_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    cfg_d.rowcol = mode_d[MODE_ROWCOL]; // RULE13
    if (upd_done)
      upd_d = upd_q + 14'h0001; // RULE14
  end

  // update sequencer
  always_comb
  begin
    ust_d = ust_q;
    upd_done = 1'b0;
    unique case (ust_q)
      UPD_IDLE:
        if (dummy_hit)
          ust_d = UPD_WAIT; // RULE15
      UPD_WAIT:
        if (!transp)
          ust_d = UPD_IDLE;
        else if (retrace ? drive_ok : ph_rise)
          ust_d = UPD_DRIVE;
      UPD_DRIVE:
        if (!transp)
          ust_d = UPD_IDLE;
        else if (retrace)
        begin
          if (!blank)
            ust_d = UPD_WAIT; // RULE8
          else if (tick)
          begin
            ust_d = UPD_IDLE;
            upd_done = 1'b1;
          end
        end
        else if (ph_fall)
        begin
          ust_d = UPD_IDLE;
          upd_done = 1'b1;
        end
    endcase
  end

  // interrupt and status flags: set beats clear
  always_comb
  begin
    ev = '0;
    ev[IRQ_UPD] = upd_done;
    ev[IRQ_VBL] = scan.vblank & ~vbl_q;
    ist_d = ist_q;
    if (wr0 && idx == IDX_IRQ_STATUS)
      ist_d = ist_q & ~wb_dat_i[IRQ_W-1:0];
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imask_d);
    ready_d = ready_q;
    if (dummy_hit || (wr0 && (idx == IDX_UPDATE_ADDRESS_LOW_REG))
        || (wr1 && (idx == IDX_UPDATE_ADDRESS_HIGH_REG)))
      ready_d = 1'b0;
    if (upd_done)
      ready_d = 1'b1; // RULE15
  end

  // memory address mux; host address never reaches the pins directly
  always_comb
  begin
    ma_d = scan.addr; // RULE2
    stb_d = 1'b0;
    if (transp && !retrace && ph_s2_q)
      ma_d = upd_q; // RULE6
    if (transp && retrace && ust_q == UPD_DRIVE && drive_ok)
    begin
      ma_d = upd_q; // RULE8
      stb_d = 1'b1; // RULE9
    end
  end

  // read mux
  always_comb
  begin
    ack_d = req;
    rdat_d = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      unique case (idx)
        IDX_STATUS:
        begin
          rdat_d[ST_UPD_READY] = ready_q;
          rdat_d[ST_VRETRACE] = scan.vblank; // RULE5
        end
        IDX_IRQ_STATUS: rdat_d[IRQ_W-1:0] = ist_q;
        IDX_IRQ_MASK: rdat_d[IRQ_W-1:0] = imask_q;
        IDX_MODE_CONTROL_REG: rdat_d[7:0] = mode_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= '{htotal: HTOTAL_RST, hdisp: HDISP_RST,
                 vtotal: VTOTAL_RST, vdisp: VDISP_RST,
                 maxscan: MAXSCAN_RST, start: ADDR_RST, rowcol: 1'b0};
      mode_q <= MODE_RST;
      upd_q <= ADDR_RST;
      ready_q <= 1'b0;
      ist_q <= '0;
      imask_q <= '0;
      ust_q <= UPD_IDLE;
      vbl_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      display_memory_address_out_o <= ADDR_RST;
      update_strobe_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      upd_q <= upd_d;
      ready_q <= ready_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      ust_q <= ust_d;
      vbl_q <= scan.vblank;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
      display_memory_address_out_o <= ma_d;
      update_strobe_o <= stb_d;
      irq_o <= irq_d;
    end
  end

  crt_addr_gen u_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .cfg_i(cfg_q),
    .scan_o(scan)
  );

  crt_skew u_skew (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .raw_i({cursor_i, ~blank}),
    .skew_i({mode_q[MODE_CUR_SKEW], mode_q[MODE_DE_SKEW]}), // RULE11
    .out_o({cursor_o, display_enable_o})
  );

  property p_interleave;
    @(posedge clk_i) disable iff (rst_i)
    (transp && !retrace && ph_s2_q) |=>
      display_memory_address_out_o == $past(upd_q);
  endproperty
  a_interleave: assert property (p_interleave) // RULE6
    else $error("update address missing in high phase");

  property p_stb_blank;
    @(posedge clk_i) disable iff (rst_i)
    update_strobe_o |-> $past(blank) && $past(ust_q) == UPD_DRIVE;
  endproperty
  a_stb_blank: assert property (p_stb_blank) // RULE8
    else $error("update strobe outside blanking");

  property p_stb_addr;
    @(posedge clk_i) disable iff (rst_i)
    update_strobe_o |-> display_memory_address_out_o == $past(upd_q);
  endproperty
  a_stb_addr: assert property (p_stb_addr) // RULE9
    else $error("strobe without update address");

  property p_incr;
    @(posedge clk_i) disable iff (rst_i)
    upd_done |=> upd_q == $past(upd_q) + 14'h0001 ##0 ready_q;
  endproperty
  a_incr: assert property (p_incr) // RULE14
    else $error("update address not incremented");

  property p_dummy;
    @(posedge clk_i) disable iff (rst_i)
    (dummy_hit && ust_q == UPD_IDLE) |=> !ready_q && ust_q == UPD_WAIT;
  endproperty
  a_dummy: assert property (p_dummy) // RULE15
    else $error("dummy access did not start an update");

  property p_vstat;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && idx == IDX_STATUS) |=>
      wb_dat_o[ST_VRETRACE] == $past(scan.vblank) && wb_ack_o;
  endproperty
  a_vstat: assert property (p_vstat) // RULE5
    else $error("retrace bit does not follow blanking");

  property p_shared;
    @(posedge clk_i) disable iff (rst_i)
    !transp |=> display_memory_address_out_o == $past(scan.addr);
  endproperty
  a_shared: assert property (p_shared) // RULE2
    else $error("shared mode address not refresh");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack held two cycles");

  c_retrace_upd: cover property (@(posedge clk_i) disable iff (rst_i)
    update_strobe_o ##[1:100] ready_q);
  c_ilv_upd: cover property (@(posedge clk_i) disable iff (rst_i)
    upd_done && !retrace);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  c_vbl: cover property (@(posedge clk_i) disable iff (rst_i)
    ev[IRQ_VBL]);
endmodule : crt_display_addr

/* sim/crt_far_model.sv */
`timescale 1ns/1ns
module crt_far_model
  import crt_pkg::*;
#(
  parameter int CHAR_HALF = 4,
  parameter int PHI_HALF = 6
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] addr_i,
  input wire logic strobe_i,
  input wire logic [7:0] hold_i,
  input wire logic [13:0] host_addr_i,
  input wire logic host_req_i,
  input wire logic ilv_i,
  output logic character_clock_o,
  output logic phi2_o,
  output logic [13:0] last_addr_o,
  output logic [13:0] ram_addr_o
);
  int cc_q;
  int ph_q;
  logic [7:0] ram [0:16383];

  // both clocks run free, unrelated to any frame
  always_ff @(posedge clk_i)
  begin
    cc_q <= (cc_q == 2 * CHAR_HALF - 1) ? 0 : cc_q + 1;
    ph_q <= (ph_q == 2 * PHI_HALF - 1) ? 0 : ph_q + 1;
  end
  assign character_clock_o = (cc_q < CHAR_HALF);
  assign phi2_o = (ph_q < PHI_HALF);

  // shared mode: contention sits out here, the controller never arbitrates
  assign ram_addr_o = ilv_i ? (phi2_o ? host_addr_i : addr_i)
                            : (host_req_i ? host_addr_i : addr_i);

  // held character lands only while the strobe marks the update address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      last_addr_o <= 14'h0000;
    else if (strobe_i)
    begin
      ram[addr_i] <= hold_i;
      last_addr_o <= addr_i;
    end
  end
endmodule : crt_far_model

/* sim/crt_display_addr_tb.sv */
`timescale 1ns/1ns
module crt_display_addr_tb;
  import crt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o, character_clock_i, phi2_i;
  logic cursor_i = 1'b0;
  logic [13:0] display_memory_address_out_o;
  logic [13:0] last_addr;
  logic update_strobe_o, display_enable_o, cursor_o, irq_o;
  logic [7:0] hold = 8'h5a;
  logic [13:0] host_addr = 14'h0000;
  logic [13:0] ram_addr;
  logic host_req = 1'b0;
  logic ilv = 1'b0;
  int miscompares = 0;
  int n_tests = 0;

  crt_display_addr DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .character_clock_i, .phi2_i, .cursor_i, .display_memory_address_out_o,
    .update_strobe_o, .display_enable_o, .cursor_o, .irq_o);

  crt_far_model u_far (.clk_i, .rst_i, .addr_i(display_memory_address_out_o),
    .strobe_i(update_strobe_o), .hold_i(hold),
    .host_addr_i(host_addr), .host_req_i(host_req), .ilv_i(ilv),
    .character_clock_o(character_clock_i), .phi2_o(phi2_i),
    .last_addr_o(last_addr), .ram_addr_o(ram_addr));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic wb(input logic we, input logic [5:0] idx,
                    input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    // no local limit: only the watchdog ends a hung access
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // sampled at each raw character edge, well before outputs move
  task automatic scan_check(input logic [7:0] mode, input logic [5:0] sh,
                            input logic [7:0] sl);
    int n, r, c;
    logic [13:0] ea;
    wb(1'b1, IDX_START_HI, {2'b00, sh});
    wb(1'b1, IDX_START_LO, sl);
    wb(1'b1, IDX_MODE_CONTROL_REG, mode);
    n = 0;
    while (display_memory_address_out_o !== {sh, sl} && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    for (int k = 0; k < 40; k++)
    begin
      r = k / 10;
      c = k % 10;
      ea = mode[MODE_ROWCOL] ? {sh + 6'(r), sl + 8'(c)}
                             : {sh, sl} + 14'(4 * r + c);
      @(posedge character_clock_i);
      check(display_memory_address_out_o, ea);
      check(display_enable_o, (r < 3) && (mode[MODE_DE_SKEW] ?
            (c >= 1 && c <= 4) : c < 4));
      if (c == 4 && r % 3 == 0)
      begin
        wb(1'b0, IDX_STATUS, 8'h00);
        check(rd[ST_VRETRACE], r == 3);
      end
    end
  endtask : scan_check

  task automatic cursor_skew;
    wb(1'b1, IDX_MODE_CONTROL_REG, 8'h00);
    cursor_i <= 1'b1;
    step(2);
    check(cursor_o, 1'b1);
    @(posedge clk_i);
    cursor_i <= 1'b0;
    wb(1'b1, IDX_MODE_CONTROL_REG, 8'h20);
    @(posedge character_clock_i);
    step(5);
    @(negedge character_clock_i);
    cursor_i <= 1'b1;
    step(2);
    check(cursor_o, 1'b0);
    @(posedge character_clock_i);
    step(5);
    check(cursor_o, 1'b1);
    @(posedge clk_i);
    cursor_i <= 1'b0;
  endtask : cursor_skew

  task automatic phase_check(input logic [13:0] a);
    // mid-phase samples, clear of the two-stage pin synchroniser lag
    @(negedge phi2_i);
    step(4);
    check(display_memory_address_out_o == a, 1'b0);
    @(posedge phi2_i);
    step(4);
    check(display_memory_address_out_o, a);
  endtask : phase_check

  task automatic interleave;
    int n;
    wb(1'b1, IDX_IRQ_MASK, 8'h00);
    wb(1'b1, IDX_MODE_CONTROL_REG, 8'h08);
    wb(1'b0, IDX_MODE_CONTROL_REG, 8'h00);
    check(rd, 32'h08);
    wb(1'b1, IDX_UPDATE_ADDRESS_HIGH_REG, 8'h12);
    wb(1'b1, IDX_UPDATE_ADDRESS_LOW_REG, 8'h34);
    wb(1'b0, IDX_STATUS, 8'h00);
    check(rd[ST_UPD_READY], 1'b0);
    phase_check(14'h1234);
    wb(1'b0, IDX_DUMMY_UPDATE_LOCATION, 8'h00);
    n = 0;
    do
    begin
      wb(1'b0, IDX_STATUS, 8'h00);
      n++;
    end
    while (rd[ST_UPD_READY] !== 1'b1 && n < 20);
    check(rd[ST_UPD_READY], 1'b1);
    check(irq_o, 1'b0);
    wb(1'b0, IDX_IRQ_STATUS, 8'h00);
    check(rd[IRQ_UPD], 1'b1);
    wb(1'b1, IDX_IRQ_MASK, 8'h01);
    step(2);
    check(irq_o, 1'b1);
    wb(1'b1, IDX_IRQ_STATUS, 8'h01);
    step(2);
    check(irq_o, 1'b0);
    phase_check(14'h1235);
  endtask : interleave

  task automatic retrace(input logic [13:0] a);
    logic seen;
    seen = 1'b0;
    wb(1'b1, IDX_DUMMY_UPDATE_LOCATION, 8'h00);
    for (int n = 0; n < 1500; n++)
    begin
      step(1);
      if (update_strobe_o === 1'b1)
      begin
        seen = 1'b1;
        check(display_memory_address_out_o, a);
        check(display_enable_o, 1'b0);
      end
      else if (seen)
        break;
    end
    check(seen, 1'b1);
    check(last_addr, a);
    check(u_far.ram[a], hold);
    step(2);
    wb(1'b0, IDX_STATUS, 8'h00);
    check(rd[ST_UPD_READY], 1'b1);
  endtask : retrace

  // shared mode: host reaches the RAM only through the outside mux
  task automatic shared;
    wb(1'b1, IDX_MODE_CONTROL_REG, 8'h00);
    wb(1'b0, IDX_DUMMY_UPDATE_LOCATION, 8'h00);
    host_addr <= 14'h3ff0;
    step(2);
    check(ram_addr, display_memory_address_out_o);
    @(posedge clk_i);
    host_req <= 1'b1;
    step(1);
    check(ram_addr, 14'h3ff0);
    check(display_memory_address_out_o == 14'h3ff0, 1'b0);
    @(posedge clk_i);
    host_req <= 1'b0;
    ilv <= 1'b1;
    @(posedge phi2_i);
    step(1);
    check(ram_addr, 14'h3ff0);
    @(negedge phi2_i);
    step(1);
    check(ram_addr, display_memory_address_out_o);
    @(posedge clk_i);
    ilv <= 1'b0;
    wb(1'b0, IDX_STATUS, 8'h00);
    check(rd[ST_UPD_READY], 1'b1);
  endtask : shared

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_MODE_CONTROL_REG, 8'h00);
    check(rd, 32'h0);
    wb(1'b0, IDX_IRQ_MASK, 8'h00);
    check(rd, 32'h0);
    check(irq_o, 1'b0);
    wb(1'b0, 6'h3f, 8'h00);
    check(rd, 32'h0);
    // a short frame keeps every scan run to a few hundred cycles
    wb(1'b1, IDX_HTOTAL, 8'h09);
    wb(1'b1, IDX_HDISP, 8'h04);
    wb(1'b1, IDX_VTOTAL, 8'h05);
    wb(1'b1, IDX_VDISP, 8'h03);
    wb(1'b0, IDX_HTOTAL, 8'h00);
    check(rd, 32'h0);
    scan_check(8'h00, 6'h01, 8'h00);
    scan_check(8'h04, 6'h02, 8'h05);
    scan_check(8'h10, 6'h00, 8'h00);
    cursor_skew;
    interleave;
    wb(1'b1, IDX_MODE_CONTROL_REG, 8'h88);
    wb(1'b1, IDX_UPDATE_ADDRESS_HIGH_REG, 8'h0a);
    wb(1'b1, IDX_UPDATE_ADDRESS_LOW_REG, 8'hbc);
    retrace(14'h0abc);
    retrace(14'h0abd);
    shared;
    tally_and_finish;
  end

  initial
  begin
    #(50 * 40000);
    miscompares++;
    tally_and_finish;
  end
endmodule : crt_display_addr_tb
